// File: pmi_host_model.sv
// Purpose: two-wire bus master model
// Assumes: sda_line is the pulled-up wire
// Notes: scl phases of six pclk
`timescale 1ns/100ps
`default_nettype none
module pmi_host_model (
   // clock
   input wire logic pclk,
   // resolved data wire
   input wire logic sda_line,
   // driven lines, high means released
   output logic scl,
   output logic sda_drv,
   // one-cycle strobe per byte seen by the master
   output logic rx_stb,
   output logic [7:0] rx_val
);
   // ==========
   // idle bus: scl stands high between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      rx_stb = 1'b0;
      rx_val = 8'h00;
   end
   // one scl phase
   task automatic hold();
      repeat (6) @(posedge pclk);
   endtask : hold
   // strobe to the bench monitor
   task automatic pulse(input logic [7:0] v);
      rx_val <= v;
      rx_stb <= 1'b1;
      @(posedge pclk);
      rx_stb <= 1'b0;
   endtask : pulse
   // start, also a repeated start from scl low
   task automatic start();
      sda_drv <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b0;
      hold();
   endtask : start
   // stop, only once the sender has let go
   task automatic stop();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b1;
      hold();
   endtask : stop
   // data set while scl low, sampled late in the high phase
   task automatic clk_bit(input logic b, output logic s);
      sda_drv <= b;
      hold();
      scl <= 1'b1;
      hold();
      s = sda_line;
      scl <= 1'b0;
      hold();
   endtask : clk_bit
   // byte out msb first, then sample the ack
   task automatic wr_byte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(b[i], s);
      end
      clk_bit(1'b1, s);
      pulse({7'h00, !s});
   endtask : wr_byte
   // byte in, then ack or withhold it
   task automatic rd_byte(input logic m_ack);
      logic [7:0] b;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, b[i]);
      end
      clk_bit(!m_ack, s);
      pulse(b);
   endtask : rd_byte
endmodule : pmi_host_model
`default_nettype wire

// File: pmi_line_sync.sv
// Purpose: two stage pin synchroniser
// Assumes: inputs come straight from pins
// Notes: only the second stage leaves this module
`timescale 1ns/100ps
`default_nettype none
module pmi_line_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // raw pins: scl, sda, upper chip strap
   input wire logic [2:0] pins_raw,
   // synchronised copy
   output logic [2:0] pins_sync
);
   // ==========
   // state
   typedef struct packed {
      logic [2:0] meta; // first stage, read by stage two only
      logic [2:0] sync; // second stage
   } pmi_sync_state_type;

   pmi_sync_state_type q, d;

   // shift one stage per clock
   always_comb begin
      d = q;
      d.meta = pins_raw;
      d.sync = q.meta;
   end

   // reset to the idle level of the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= {pmi_pkg::SYNC_RESET, pmi_pkg::SYNC_RESET};
      end else begin
         q <= d;
      end
   end

   assign pins_sync = q.sync;
endmodule : pmi_line_sync
`default_nettype wire

// File: pmi_pkg.sv
// Purpose: constants and types of the serial slave
// Assumes: eleven byte registers
// Notes: apb byte address is four times the index
package pmi_pkg;
   // ==========
   // register space
   localparam int NUM_REGS = 11;                 // indices 0 .. 10
   localparam logic [3:0] PTR_LAST = 4'h a;      // pointer wraps after this
   localparam logic [3:0] IDX_CELL_BAL = 4'h 1;  // one bit per cell
   localparam logic [3:0] IDX_AO_SEL = 4'h 2;    // analog output select
   localparam logic [3:0] IDX_SWITCH = 4'h 3;    // switch bits and forced reset
   localparam logic [3:0] IDX_USER_FLAG = 4'h 4; // battery backed flags
   localparam logic [3:0] IDX_STATUS = 4'h b;    // read only, apb side only
   // ==========
   // field positions
   localparam int BIT_CHARGE = 0;                // charge_switch_bit
   localparam int BIT_DISCHARGE = 1;             // discharge_switch_bit
   localparam int BIT_FORCE_POR = 7;             // self clearing, never stored
   localparam int CELL_COUNT = 6;
   localparam int AO_SEL_W = 4;
   localparam int FLAG_W = 4;
   // ==========
   // serial bus
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h 28; // 0101 000
   localparam logic [3:0] BITS_PER_BYTE = 4'h 8;
   localparam logic [3:0] LAST_TX_BIT = 4'h 7;
   localparam logic [2:0] SYNC_RESET = 3'h 3;       // lines idle high
   // ==========
   // apb
   localparam int PADDR_W = 12;
   localparam logic [1:0] WORD_ALIGN = 2'h 0;
   localparam logic [5:0] UPPER_ZERO = 6'h 00;

   // ==========
   // serial engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100,
      ST_IGNORE = 3'b101
   } pmi_state_type;

   // which byte of a transfer is being received
   typedef enum logic [1:0] {
      PH_SLAVE = 2'b00,
      PH_POINTER = 2'b01,
      PH_DATA = 2'b10
   } pmi_phase_type;
endpackage : pmi_pkg

// File: pmi_regfile.sv
// Purpose: byte register space and the functions it drives directly
// Assumes: one write per cycle, arbitrated by the caller
// Notes: flags clear on presetn, a forced reset write or a write to them
`timescale 1ns/100ps
`default_nettype none
module pmi_regfile (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [7:0] wr_data,
   // two read ports
   input wire logic [3:0] rd_idx_a,
   output logic [7:0] rd_data_a,
   input wire logic [3:0] rd_idx_b,
   output logic [7:0] rd_data_b,
   // protection input
   input wire logic over_temp_shutdown,
   // controlled functions
   output logic [pmi_pkg::CELL_COUNT-1:0] cell_balance_on,
   output logic [pmi_pkg::AO_SEL_W-1:0] analog_monitor_select,
   output logic charge_switch_bit,
   output logic discharge_switch_bit,
   output logic [pmi_pkg::FLAG_W-1:0] user_flag
);
   // ==========
   // state
   typedef struct packed {
      logic [pmi_pkg::NUM_REGS-1:0][7:0] mem; // register array
   } pmi_reg_state_type;

   pmi_reg_state_type q, d;

   // out of range reads give zero
   function automatic logic [7:0] rd_byte(input pmi_reg_state_type s, input logic [3:0] i);
      rd_byte = (i <= pmi_pkg::PTR_LAST) ? s.mem[i] : 8'h 00;
   endfunction : rd_byte

   // write handling with side effects
   always_comb begin
      d = q;
      if (wr_en && wr_idx <= pmi_pkg::PTR_LAST) begin
         if (wr_idx == pmi_pkg::IDX_SWITCH && wr_data[pmi_pkg::BIT_FORCE_POR]) begin
            d.mem = '0; // forced reset wipes flags too
         end else if (over_temp_shutdown && wr_idx == pmi_pkg::IDX_CELL_BAL) begin
            d = q; // balance writes dropped while hot
         end else if (over_temp_shutdown && wr_idx == pmi_pkg::IDX_SWITCH) begin
            // switch bits kept, rest of the byte still written
            d.mem[wr_idx] = wr_data;
            d.mem[wr_idx][pmi_pkg::BIT_CHARGE] = q.mem[wr_idx][pmi_pkg::BIT_CHARGE];
            d.mem[wr_idx][pmi_pkg::BIT_DISCHARGE] = q.mem[wr_idx][pmi_pkg::BIT_DISCHARGE];
         end else begin
            d.mem[wr_idx] = wr_data; // flags set or cleared by write
         end
         d.mem[pmi_pkg::IDX_SWITCH][pmi_pkg::BIT_FORCE_POR] = 1'b0;
      end
   end

   // presetn or a forced reset write clears; standby does not touch the array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rd_data_a = rd_byte(q, rd_idx_a);
   assign rd_data_b = rd_byte(q, rd_idx_b);
   // one switch per set bit
   assign cell_balance_on = q.mem[pmi_pkg::IDX_CELL_BAL][pmi_pkg::CELL_COUNT-1:0];
   // mux select to the analog output
   assign analog_monitor_select = q.mem[pmi_pkg::IDX_AO_SEL][pmi_pkg::AO_SEL_W-1:0];
   assign charge_switch_bit = q.mem[pmi_pkg::IDX_SWITCH][pmi_pkg::BIT_CHARGE];
   assign discharge_switch_bit = q.mem[pmi_pkg::IDX_SWITCH][pmi_pkg::BIT_DISCHARGE];
   assign user_flag = q.mem[pmi_pkg::IDX_USER_FLAG][pmi_pkg::FLAG_W-1:0];
endmodule : pmi_regfile
`default_nettype wire

// File: pmi_top.sv
// Purpose: two-wire slave port with an apb view of its registers
// Assumes: pclk much faster than scl
// Notes: sda is open drain, only ever pulled low; scl is never driven
//
// How it works
// - bytes shift msb first
// - data changes only while clock low
// - start is sda falling, scl high
// - ignore bus until a start
// - stop is sda rising, scl high
// - stop after read enters standby
// - ninth clock carries receiver acknowledge
// - acknowledge only own slave address
// - acknowledge every written byte
// - read sends bytes while master acknowledges
// - master nack ends read, line released
// - four user flags writable
// - flags survive standby and wake
// - forced reset clears the flags
// - balance bit set keeps switch on
// - select bits route the analog output
// - shutdown ignores switch and balance writes, except a forced reset
// - pointer increments, wraps after 0x0a
// - strap picks lower or upper address
`timescale 1ns/100ps
`default_nettype none
module pmi_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmi_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // two-wire bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // cascade position strap, high for the upper chip
   input wire logic upper_chip_strap,
   // protection input
   input wire logic over_temp_shutdown,
   // controlled functions
   output logic [pmi_pkg::CELL_COUNT-1:0] cell_balance_on,
   output logic [pmi_pkg::AO_SEL_W-1:0] analog_monitor_select,
   output logic charge_switch_bit,
   output logic discharge_switch_bit,
   output logic [pmi_pkg::FLAG_W-1:0] user_flag,
   output logic standby
);
   // ==========
   // state
   typedef struct packed {
      pmi_pkg::pmi_state_type state; // serial engine
      pmi_pkg::pmi_phase_type phase; // byte role in transfer
      logic [3:0] cnt;               // bit counter
      logic [7:0] shift;             // receive shifter
      logic [7:0] tx_byte;           // transmit shifter
      logic [3:0] ptr;               // register pointer
      logic rw;                      // read bit of slave byte
      logic ack_seen;                // master acknowledge on read
      logic read_seen;               // transfer included a read
      logic sda_oe;                  // pulling sda low
      logic scl_prev;                // edge detection history
      logic sda_prev;
      logic standby;                 // standby power state
      logic strap_done;              // set after the first cycle, then strap followed
      logic upper;                   // caught strap
      logic apb_ack;                 // answer cycle
      logic [31:0] prdata;
      logic pslverr;
   } pmi_top_state_type;

   pmi_top_state_type q, d;

   // ==========
   // synchronised pins
   logic [2:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic strap_s;

   pmi_line_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins_raw({upper_chip_strap, sda_i, scl_i}),
      .pins_sync(pins_sync)
   );

   assign scl_s = pins_sync[0];
   assign sda_s = pins_sync[1];
   assign strap_s = pins_sync[2];

   // ==========
   // register file
   logic i2c_we;
   logic apb_we;
   logic [7:0] i2c_rd;
   logic [7:0] apb_rd;
   logic [3:0] apb_idx;
   logic apb_mapped;

   pmi_regfile u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(i2c_we | apb_we),
      .wr_idx(i2c_we ? q.ptr : apb_idx),
      .wr_data(i2c_we ? q.shift : pwdata[7:0]),
      .rd_idx_a(q.ptr),
      .rd_data_a(i2c_rd),
      .rd_idx_b(apb_idx),
      .rd_data_b(apb_rd),
      .over_temp_shutdown(over_temp_shutdown),
      .cell_balance_on(cell_balance_on),
      .analog_monitor_select(analog_monitor_select),
      .charge_switch_bit(charge_switch_bit),
      .discharge_switch_bit(discharge_switch_bit),
      .user_flag(user_flag)
   );

   // pointer step used by reads and writes
   function automatic logic [3:0] next_ptr(input logic [3:0] p);
      next_ptr = (p == pmi_pkg::PTR_LAST) ? 4'h 0 : p + 4'h 1; // wrap after last
   endfunction : next_ptr

   // ==========
   // bus conditions, seen on synchronised lines
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [6:0] own_addr;

   assign scl_rise = scl_s & ~q.scl_prev;
   assign scl_fall = ~scl_s & q.scl_prev;
   // sda moving while scl high is only start or stop
   assign start_cond = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
   assign stop_cond = scl_s & q.scl_prev & ~q.sda_prev & sda_s;
   // strap sets the lowest address bit
   assign own_addr = pmi_pkg::SLAVE_ADDR_BASE | {6'h 00, q.upper};

   // apb decode: word aligned, index up to the status word
   assign apb_idx = paddr[5:2];
   assign apb_mapped = (paddr[1:0] == pmi_pkg::WORD_ALIGN) && (paddr[11:6] == pmi_pkg::UPPER_ZERO)
                       && (apb_idx <= pmi_pkg::IDX_STATUS);

   // ==========
   // serial engine and apb answer
   always_comb begin
      d = q;
      d.scl_prev = scl_s;
      d.sda_prev = sda_s;
      i2c_we = 1'b0;
      apb_we = 1'b0;
      // follow the strap from the second cycle; its first copy is the sync pipe's reset level
      d.strap_done = 1'b1;
      if (q.strap_done) begin
         d.upper = strap_s;
      end
      if (start_cond) begin
         // start anywhere aborts the byte in flight
         d.state = pmi_pkg::ST_RX;
         d.phase = pmi_pkg::PH_SLAVE;
         d.cnt = 4'h 0;
         d.sda_oe = 1'b0;
         d.standby = 1'b0; // any start wakes the part
      end else if (stop_cond) begin
         // stop ends the transaction; after a read, go to standby
         if (q.read_seen) begin
            d.standby = 1'b1;
         end
         d.read_seen = 1'b0;
         d.state = pmi_pkg::ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         case (q.state)
            pmi_pkg::ST_IDLE: begin
               d.sda_oe = 1'b0; // deaf until a start
            end
            pmi_pkg::ST_RX: begin
               if (scl_rise && q.cnt < pmi_pkg::BITS_PER_BYTE) begin
                  d.shift = {q.shift[6:0], sda_s}; // msb arrives first
                  d.cnt = q.cnt + 4'h 1;
               end
               if (scl_fall && q.cnt == pmi_pkg::BITS_PER_BYTE) begin
                  d.cnt = 4'h 0;
                  case (q.phase)
                     pmi_pkg::PH_SLAVE: begin
                        if (q.shift[7:1] == own_addr) begin
                           d.rw = q.shift[0];
                           d.sda_oe = 1'b1; // own address acknowledged
                           d.state = pmi_pkg::ST_RX_ACK;
                        end else begin
                           d.state = pmi_pkg::ST_IGNORE; // foreign address, no ack
                        end
                     end
                     pmi_pkg::PH_POINTER: begin
                        // pointer beyond the map starts at zero
                        d.ptr = (q.shift[3:0] <= pmi_pkg::PTR_LAST && q.shift[7:4] == 4'h 0)
                                ? q.shift[3:0] : 4'h 0;
                        d.sda_oe = 1'b1;
                        d.state = pmi_pkg::ST_RX_ACK;
                     end
                     default: begin
                        i2c_we = 1'b1; // byte stored at the fall after bit 8
                        d.sda_oe = 1'b1;
                        d.state = pmi_pkg::ST_RX_ACK;
                     end
                  endcase
               end
            end
            pmi_pkg::ST_RX_ACK: begin
               // hold sda low for the whole ninth clock
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.state = pmi_pkg::ST_RX;
                  if (q.phase == pmi_pkg::PH_SLAVE && q.rw) begin
                     // read: first bit placed while scl is low
                     d.state = pmi_pkg::ST_TX;
                     d.tx_byte = i2c_rd;
                     d.sda_oe = ~i2c_rd[7]; // msb first
                     d.cnt = 4'h 0;
                     d.read_seen = 1'b1;
                  end else if (q.phase == pmi_pkg::PH_SLAVE) begin
                     d.phase = pmi_pkg::PH_POINTER;
                  end else if (q.phase == pmi_pkg::PH_POINTER) begin
                     d.phase = pmi_pkg::PH_DATA;
                  end else begin
                     d.ptr = next_ptr(q.ptr); // burst write
                  end
               end
            end
            pmi_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (q.cnt == pmi_pkg::LAST_TX_BIT) begin
                     d.sda_oe = 1'b0; // release for the master ack
                     d.ptr = next_ptr(q.ptr); // step after the eighth bit
                     d.state = pmi_pkg::ST_TX_ACK;
                  end else begin
                     d.tx_byte = {q.tx_byte[6:0], 1'b0};
                     d.sda_oe = ~q.tx_byte[6];
                     d.cnt = q.cnt + 4'h 1;
                  end
               end
            end
            pmi_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  d.ack_seen = ~sda_s; // sample master acknowledge
               end
               if (scl_fall) begin
                  d.cnt = 4'h 0;
                  if (q.ack_seen) begin
                     d.state = pmi_pkg::ST_TX; // next byte
                     d.tx_byte = i2c_rd;
                     d.sda_oe = ~i2c_rd[7];
                  end else begin
                     d.state = pmi_pkg::ST_IGNORE; // nack: stay released
                     d.sda_oe = 1'b0;
                  end
               end
            end
            pmi_pkg::ST_IGNORE: begin
               d.sda_oe = 1'b0; // wait for stop or start; master's duty
            end
            default: begin
               d.state = pmi_pkg::ST_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end
      // apb answer; a serial write that cycle delays it
      d.apb_ack = 1'b0;
      if (psel && penable && !q.apb_ack && !i2c_we) begin
         d.apb_ack = 1'b1;
         d.pslverr = ~apb_mapped;
         d.prdata = 32'h 0000_0000;
         if (apb_mapped && apb_idx == pmi_pkg::IDX_STATUS) begin
            // status word is read only
            d.prdata = {22'h 00_0000, q.ptr, q.standby, q.state, q.upper, q.read_seen};
         end else if (apb_mapped) begin
            d.prdata = {24'h 00_0000, apb_rd};
            apb_we = pwrite;
         end
      end
   end

   // ==========
   // one register stage for all state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // open drain: the level driven is always low, only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe = q.sda_oe;
   assign standby = q.standby;
   assign pready = q.apb_ack;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr & q.apb_ack;
endmodule : pmi_top
`default_nettype wire

// File: pmi_top_sva.sv
// Purpose: port checks of the serial slave
// Assumes: scl phases of four pclk or more
// Notes: bound at the foot
`timescale 1ns/100ps
`default_nettype none
module pmi_top_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // two-wire pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // protection and controlled functions
   input wire logic over_temp_shutdown,
   input wire logic [pmi_pkg::CELL_COUNT-1:0] cell_balance_on,
   input wire logic [pmi_pkg::FLAG_W-1:0] user_flag,
   input wire logic standby
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========
   // helper: has a start been seen since reset
   typedef struct packed {logic sda; logic seen;} pmi_sva_type;
   pmi_sva_type st_q, st_d;
   always_comb begin
      st_d.sda = sda_i;
      st_d.seen = st_q.seen | (scl_i & st_q.sda & ~sda_i);
   end
   // raw lines, so the flag leads the design's view
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= 2'b10;
      end else begin
         st_q <= st_d;
      end
   end
   // ==========
   // bus conditions
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   sequence s_held;
      sda_oe [*4];
   endsequence
   a_quiet_before_start: assert property (!st_q.seen |-> !sda_oe)
      else $error("pulled before start");
   a_change_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("sda moved, scl high");
   a_line_only_low: assert property (sda_oe |-> sda_o == 1'b0)
      else $error("sda driven high");
   a_drive_held: assert property ($rose(sda_oe) |-> s_held)
      else $error("ack cut short");
   a_standby_at_stop: assert property ($rose(standby) |-> scl_i && sda_i)
      else $error("standby without stop");
   a_start_wakes: assert property (s_start |-> ##[1:8] !standby)
      else $error("standby kept");
   a_flags_kept: assert property ($rose(standby) |-> $stable(user_flag) ##1 $stable(user_flag))
      else $error("flags changed");
   a_shutdown_freeze: assert property (over_temp_shutdown && $past(over_temp_shutdown)
      |-> $stable(cell_balance_on) || cell_balance_on == '0)
      else $error("balance changed");
endmodule : pmi_top_sva
bind pmi_top pmi_top_sva u_sva (.pclk, .presetn, .scl_i, .sda_i, .sda_o, .sda_oe,
   .over_temp_shutdown, .cell_balance_on, .user_flag, .standby);
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench
// Assumes: lower chip position, strap tied low
// Notes: expected results queue up
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ==========
   // clock, reset and pins
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, ot, pready, pslverr, sda_o, sda_oe;
   logic scl, sda_drv, rx_stb, standby, chg, dis;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [7:0] rx_val;
   logic [7:0] d [3];
   logic [5:0] bal;
   logic [3:0] sel, flag;
   wire logic sda_line;
   int bad_count = 0;
   int checks = 0;
   string q_n[$];
   logic [32:0] q_v[$];
   always #4 pclk = ~pclk;
   // open drain wire with pull-up
   assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
   pmi_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe, .upper_chip_strap(1'b0), .over_temp_shutdown(ot),
      .cell_balance_on(bal), .analog_monitor_select(sel), .charge_switch_bit(chg),
      .discharge_switch_bit(dis), .user_flag(flag), .standby);
   pmi_host_model host (.pclk, .sda_line, .scl, .sda_drv, .rx_stb, .rx_val);
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic note(input string n, input logic [32:0] v);
      q_n.push_back(n);
      q_v.push_back(v);
   endtask : note
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   // apb master: request held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, v};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // serial byte, answer noted
   task automatic sw(input logic [7:0] b, input logic ack);
      note("serial ack", 33'(ack));
      host.wr_byte(b);
   endtask : sw
   task automatic sr(input logic m_ack, input logic [7:0] exp);
      note("serial read", 33'(exp));
      host.rd_byte(m_ack);
   endtask : sr
   // one serial register write
   task automatic swr(input logic [7:0] idx, input logic [7:0] v);
      host.start();
      sw(8'h50, 1'b1);
      sw(idx, 1'b1);
      sw(v, 1'b1);
      host.stop();
   endtask : swr
   // oldest note vs each result
   always @(posedge pclk) begin
      if (rx_stb === 1'b1 || (psel & penable & pready & ~pwrite) === 1'b1) begin
         check(q_n.pop_front(), rx_stb ? 33'(rx_val) : {pslverr, prdata}, q_v.pop_front());
      end
   end
   // watchdog
   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      $display("watchdog expired");
      print_verdict();
   end
   // ==========
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ot = 1'b0;
      rnd = 32'h0001_1d92;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      for (int i = 1; i < 5; i++) begin
         note("reset value", 33'h0);
         apb(1'b0, 12'(4 * i), 8'h00);
      end
      host.scl <= 1'b0; // clock low before data moves
      host.hold();
      sw(8'h50, 1'b0);
      host.start();
      sw(8'h52, 1'b0);
      host.stop();
      $display("test reset and address done");
      // burst from index 9 wraps to 0
      rnd = lfsr_next(rnd);
      host.start();
      sw(8'h50, 1'b1);
      sw(8'h09, 1'b1);
      for (int k = 0; k < 3; k++) begin
         d[k] = rnd[8*k +: 8];
         sw(d[k], 1'b1);
      end
      host.stop();
      for (int k = 0; k < 3; k++) begin
         note("burst readback", 33'(d[k]));
         apb(1'b0, (k == 2) ? 12'h000 : 12'(36 + 4 * k), 8'h00);
      end
      // read across the wrap after a repeated start
      host.start();
      sw(8'h50, 1'b1);
      sw(8'h0a, 1'b1);
      host.start();
      sw(8'h51, 1'b1);
      sr(1'b1, d[1]);
      sr(1'b0, d[2]);
      check("released after nack", 33'(sda_oe), 33'h0);
      host.stop();
      repeat (8) @(posedge pclk);
      check("standby", 33'(standby), 33'h1);
      $display("test burst and read done");
      // balance, select, switches, flags in one burst
      rnd = lfsr_next(rnd);
      host.start();
      sw(8'h50, 1'b1);
      sw(8'h01, 1'b1);
      sw(8'(rnd[5:0]), 1'b1);
      sw(8'(rnd[11:8]), 1'b1);
      sw(8'(rnd[13:12]), 1'b1);
      sw(8'(rnd[19:16]), 1'b1);
      host.stop();
      check("standby cleared", 33'(standby), 33'h0);
      check("balance", 33'(bal), 33'(rnd[5:0]));
      check("select", 33'(sel), 33'(rnd[11:8]));
      check("switches", 33'({dis, chg}), 33'(rnd[13:12]));
      // current address read; flags survive standby
      host.start();
      sw(8'h51, 1'b1);
      sr(1'b0, 8'h00);
      host.stop();
      repeat (8) @(posedge pclk);
      check("flags kept", 33'(flag), 33'(rnd[19:16]));
      for (int v = 0; v < 16; v++) begin
         apb(1'b1, 12'h008, 8'(v)); // lowest select code set first
         check("select code", 33'(sel), 33'(v));
      end
      $display("test functions done");
      // hot: balance and switch writes dropped
      ot <= 1'b1;
      swr(8'h01, {2'b00, ~rnd[5:0]});
      swr(8'h03, {6'h00, ~rnd[13:12]});
      check("balance frozen", 33'(bal), 33'(rnd[5:0]));
      check("switches frozen", 33'({dis, chg}), 33'(rnd[13:12]));
      ot <= 1'b0;
      // forced reset clears flags
      swr(8'h03, 8'h80);
      check("flags cleared", 33'(flag), 33'h0);
      note("forced reset readback", 33'h0);
      apb(1'b0, 12'h00c, 8'h00);
      note("unmapped", 33'h1_0000_0000);
      apb(1'b0, 12'h030, 8'h00);
      check("notes left", 33'(q_v.size()), 33'h0);
      $display("test shutdown and reset done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
